// ===== dv/ffsq_asserts.sv
// interface assertions between the flash device end and the host end
`timescale 1ns/1ps
`default_nettype none
module ffsq_asserts
  import ffsq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // bus signals
  input wire logic we,
  input wire logic re,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic reset_powerdown_pin_n
);
  logic [7:0] last_r, prev_r, prev2_r;
  logic cmd_wr;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////
  // history of written codes; a data byte after a write setup is no command
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_r <= 8'h00;
      prev_r <= 8'h00;
      prev2_r <= 8'h00;
    end else if (we) begin
      last_r <= wdata;
      prev_r <= last_r;
      prev2_r <= prev_r;
    end
  end
  assign cmd_wr = we && last_r != CMD_WRITE_A && last_r != CMD_WRITE_B;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_strobes_apart: assert property (!(we && re)) else $error("write and read strobe together");
  a_chip_confirm: assert property (cmd_wr && wdata == CMD_CHIP_ERASE |=> we && wdata == CMD_CONFIRM)
    else $error("chip erase setup without confirm");
  a_lock_confirm: assert property (cmd_wr && wdata == CMD_LOCK_SETUP |=>
    we && (wdata == CMD_LOCK_BLOCK || wdata == CMD_LOCK_PERM)) else $error("lock setup without confirm");
  a_write_data: assert property (cmd_wr && (wdata == CMD_WRITE_A || wdata == CMD_WRITE_B) |=> we)
    else $error("write setup without data cycle");
  a_write_busy: assert property ((we && (last_r == CMD_WRITE_A || last_r == CMD_WRITE_B)) ##2 re
    |=> (!rdata[SB_READY] || rdata[SB_WRITE_ERR])) else $error("byte write not busy");
  a_clear_zero: assert property (re && last_r == CMD_READ_STATUS && prev_r == CMD_CLEAR_STATUS
    |=> (rdata & 8'hba) == 8'h80) else $error("flags left after clear");
  a_seq_error: assert property (re && last_r == CMD_READ_STATUS && prev_r == CMD_CONFIRM
    && prev2_r == CMD_READ_STATUS |=> rdata[5:4] == 2'b11) else $error("lone resume not flagged");
  a_flags_sticky: assert property ((re && reset_powerdown_pin_n && last_r != CMD_READ_ARRAY) ##1 !we
    ##1 (re && reset_powerdown_pin_n) |=> (($past(rdata, 2) & 8'h3a) & ~rdata) == 8'h00)
    else $error("error flag dropped while polling");
  a_pin_clears: assert property (!reset_powerdown_pin_n |=> rdata == 8'h00)
    else $error("read data kept under reset pin");
endmodule
`default_nettype wire

// ===== dv/flash_erase_write_lock_sequencer_bench.sv
// self-checking bench for host and device ends joined by the bus
`timescale 1ns/1ps
`default_nettype none
module flash_erase_write_lock_sequencer_bench;
  import ffsq_pkg::*;
  logic ref_clk_i, nrst_i, supply_ok, verify_fail, cmd_valid, powerdown, cmd_ready, done, error, seq_error;
  ffsq_op_t cmd_op;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data, result;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  ffsq_op_t bad_op[4] = '{OP_BYTE_WRITE, OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_LOCK_BLOCK};
  logic [7:0] bad_st[4] = '{8'h98, 8'ha8, 8'ha8, 8'h98};

  ////////////////////////////////////////////////////////////////////////////
  // both ends and the checker on the bus between them
  ffsq_bus_if bus();
  ffsq_device i_ffsq_device(.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus(bus),
    .program_erase_supply_ok_i(supply_ok), .verify_fail_i(verify_fail));
  ffsq_host i_ffsq_host(.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus(bus), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .powerdown_i(powerdown),
    .cmd_ready_o(cmd_ready), .done_o(done), .result_o(result), .error_o(error), .seq_error_o(seq_error));
  ffsq_asserts i_ffsq_asserts(.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .we(bus.we), .re(bus.re),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .reset_powerdown_pin_n(bus.reset_powerdown_pin_n));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total++;
      $display("BAD timeout expected done seen hang");
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hand one operation to the host end and wait for its done pulse
  task automatic do_op(input ffsq_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic ok;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do begin
      @(negedge ref_clk_i);
      ok = cmd_ready;
      @(posedge ref_clk_i);
    end while (ok !== 1'b1);
    cmd_valid <= 1'b0;
    do begin
      @(negedge ref_clk_i);
    end while (done !== 1'b1);
    @(posedge ref_clk_i);
  endtask
  task automatic st(input string what, input logic [7:0] exp);
    do_op(OP_READ_STATUS, '0, '0);
    chk(what, result, exp);
  endtask
  task automatic clr(input string what);
    do_op(OP_CLEAR_STATUS, '0, '0);
    st(what, 8'h80);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    nrst_i = 1'b0;
    supply_ok = 1'b1;
    verify_fail = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = '0;
    cmd_data = '0;
    powerdown = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    st("status after reset", 8'h80);
    do_op(OP_BLOCK_ERASE, 20'h00000, 8'h00);
    chk("erase status", result, 8'h80);
    do_op(OP_BYTE_WRITE, 20'h00012, 8'h5a);
    chk("write status", result, 8'h80);
    do_op(OP_READ_ARRAY_MODE, '0, '0);
    do_op(OP_READ, 20'h00012, '0);
    chk("written byte", result, 8'h5a);
    do_op(OP_READ, 20'h00013, '0);
    chk("erased byte", result, ERASED);
    $display("test erase and write done");
    verify_fail <= 1'b1;
    do_op(OP_BYTE_WRITE, 20'h00013, 8'h0f);
    verify_fail <= 1'b0;
    chk("failed write", result, 8'h90);
    chk("error flag", {7'h00, error}, 8'h01);
    st("sticky status", 8'h90);
    clr("cleared status");
    do_op(OP_RESUME, '0, '0);
    st("lone resume", 8'hb0);
    chk("sequence flag", {7'h00, seq_error}, 8'h01);
    clr("clear after sequence");
    $display("test error flags done");
    supply_ok <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      do_op(bad_op[i], 20'h00000, 8'h00);
      chk("supply fault", result, bad_st[i]);
      clr("clear after supply");
    end
    supply_ok <= 1'b1;
    $display("test supply done");
    do_op(OP_LOCK_BLOCK, 20'h10000, '0);
    chk("lock one block", result, 8'h80);
    do_op(OP_BYTE_WRITE, 20'h10005, 8'h33);
    chk("write locked block", result, 8'h92);
    clr("clear after protect");
    // locks issued one block at a time, the status of each checked before the next
    for (int b = 0; b < NUM_BLK; b++) begin
      do_op(OP_LOCK_BLOCK, {b[BLK_W-1:0], 16'h0000}, '0);
      chk("lock each block", result, 8'h80);
    end
    do_op(OP_BLOCK_ERASE, 20'h00000, '0);
    chk("erase locked block", result, 8'ha2);
    clr("clear after erase protect");
    do_op(OP_CHIP_ERASE, '0, '0);
    chk("chip erase all locked", result, 8'h82);
    do_op(OP_LOCK_PERM, '0, '0);
    chk("permanent lock", result, 8'h82);
    do_op(OP_LOCK_BLOCK, 20'h20000, '0);
    chk("lock under permanent", result, 8'h92);
    do_op(OP_SUSPEND, '0, '0);
    chk("suspend after finish", result, 8'h92);
    $display("test locks done");
    powerdown <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    powerdown <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    st("status after reset pin", 8'h80);
    $display("test reset pin done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== rtl/ffsq_bus_if.sv
// parallel bus between the flash device end and its host end
`timescale 1ns/1ps
`default_nettype none
interface ffsq_bus_if;
  import ffsq_pkg::*;
  logic we;
  logic re;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic reset_powerdown_pin_n;

  modport device (input we, re, addr, wdata, reset_powerdown_pin_n, output rdata);
  modport host (output we, re, addr, wdata, reset_powerdown_pin_n, input rdata);
endinterface
`default_nettype wire

// ===== rtl/ffsq_device.sv
// flash device end: command_interface, write_state_machine, status_byte and array
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ffsq_device
  import ffsq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // bus to the host
  ffsq_bus_if.device bus,
  // supply and verify conditions
  input wire logic program_erase_supply_ok_i,
  input wire logic verify_fail_i
);

  typedef struct packed {
    logic read_status;
    ffsq_pend_t pend;
    ffsq_engine_t engine;
    logic susp_erase;
    logic susp_write;
    logic [CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] tgt;
    logic [DATA_W-1:0] tdata;
    logic lock_perm;
    logic [NUM_BLK-1:0] blk_lock;
    logic perm_lock;
    logic err_erase;
    logic err_write;
    logic err_supply;
    logic err_protect;
    logic [DATA_W-1:0] rdata;
  } ffsq_dev_state_t;

  localparam ffsq_dev_state_t DEV_RST = '{
    read_status: 1'b0, pend: CI_NONE, engine: W_IDLE, susp_erase: 1'b0, susp_write: 1'b0,
    cnt: '0, tgt: '0, tdata: '0, lock_perm: 1'b0, blk_lock: '0, perm_lock: 1'b0,
    err_erase: 1'b0, err_write: 1'b0, err_supply: 1'b0, err_protect: 1'b0, rdata: '0
  };

  ffsq_dev_state_t s_r;
  ffsq_dev_state_t s_nxt;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic mem_we;
  logic [ADDR_W-1:0] mem_a;
  logic [DATA_W-1:0] mem_d;
  logic running;
  logic [DATA_W-1:0] status;
  logic [BLK_W-1:0] wblk;
  logic last;

  ////////////////////////////////////////////////////////////////////////////
  // status byte as seen by reads
  assign running = (s_r.engine != W_IDLE) && !s_r.susp_erase && !s_r.susp_write;
  assign status = {~running, s_r.susp_erase, s_r.err_erase, s_r.err_write,
                   s_r.err_supply, s_r.susp_write, s_r.err_protect, 1'b0};
  assign wblk = bus.addr[ADDR_W-1:OFS_W];
  assign last = &s_r.tgt[OFS_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // next state: operation progress, then bus reads and writes
  always_comb begin
    s_nxt = s_r;
    mem_we = 1'b0;
    mem_a = s_r.tgt;
    mem_d = ERASED;
    // progress of the running operation
    if (running) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      if (!program_erase_supply_ok_i) begin
        s_nxt.err_supply = 1'b1;
        if (s_r.engine == W_ERASE || s_r.engine == W_CHIP) begin
          s_nxt.err_erase = 1'b1;
        end else begin
          s_nxt.err_write = 1'b1;
        end
        s_nxt.engine = W_IDLE;
      end else begin
        case (s_r.engine)
          W_ERASE, W_CHIP: begin
            // one location per cycle; locked blocks are skipped in a chip erase
            mem_we = !s_r.blk_lock[s_r.tgt[ADDR_W-1:OFS_W]];
            s_nxt.tgt = s_r.tgt + 1'b1;
            if (last && (s_r.engine == W_ERASE || &s_r.tgt[ADDR_W-1:OFS_W])) begin
              s_nxt.engine = W_IDLE;
              s_nxt.tgt = s_r.tgt;
              if (verify_fail_i) begin
                s_nxt.err_erase = 1'b1;
              end
            end
          end
          W_WRITE: begin
            if (s_r.cnt == WRITE_CYC - 1'b1) begin
              mem_we = 1'b1;
              mem_d = mem[s_r.tgt] & s_r.tdata; // programming only clears bits
              s_nxt.engine = W_IDLE;
              if (verify_fail_i) begin
                s_nxt.err_write = 1'b1;
              end
            end
          end
          W_LOCK: begin
            if (s_r.cnt == LOCK_CYC - 1'b1) begin
              s_nxt.engine = W_IDLE;
              if (verify_fail_i) begin
                s_nxt.err_write = 1'b1;
              end else if (s_r.lock_perm) begin
                s_nxt.perm_lock = 1'b1;
              end else begin
                s_nxt.blk_lock[s_r.tgt[ADDR_W-1:OFS_W]] = 1'b1;
              end
            end
          end
          default: begin
            s_nxt.engine = W_IDLE;
          end
        endcase
      end
    end
    // reads: data stand in the cycle after the strobe
    if (bus.re) begin
      if (s_r.read_status || running) begin
        s_nxt.rdata = status;
      end else if (s_r.susp_write && bus.addr == s_r.tgt) begin
        s_nxt.rdata = SUSP_TARGET_DATA;
      end else begin
        s_nxt.rdata = mem[bus.addr];
      end
    end
    // writes: second cycle of a two-write sequence
    if (bus.we && s_r.pend != CI_NONE) begin
      s_nxt.pend = CI_NONE;
      s_nxt.read_status = 1'b1;
      s_nxt.cnt = '0;
      if (s_r.pend == CI_WRITE) begin
        if (!program_erase_supply_ok_i) begin
          s_nxt.err_supply = 1'b1;
          s_nxt.err_write = 1'b1;
        end else if (s_r.blk_lock[wblk]) begin
          s_nxt.err_protect = 1'b1;
          s_nxt.err_write = 1'b1;
        end else begin
          s_nxt.engine = W_WRITE;
          s_nxt.tgt = bus.addr;
          s_nxt.tdata = bus.wdata;
        end
      end else if (s_r.pend == CI_LOCK) begin
        if (bus.wdata != CMD_LOCK_BLOCK && bus.wdata != CMD_LOCK_PERM) begin
          s_nxt.err_erase = 1'b1;
          s_nxt.err_write = 1'b1;
        end else if (!program_erase_supply_ok_i) begin
          s_nxt.err_supply = 1'b1;
          s_nxt.err_write = 1'b1;
        end else if (s_r.perm_lock) begin
          s_nxt.err_protect = 1'b1; // lock bits frozen once permanent lock set
          s_nxt.err_write = 1'b1;
        end else begin
          s_nxt.engine = W_LOCK;
          s_nxt.tgt = bus.addr;
          s_nxt.lock_perm = (bus.wdata == CMD_LOCK_PERM);
        end
      end else if (bus.wdata != CMD_CONFIRM) begin
        s_nxt.err_erase = 1'b1;
        s_nxt.err_write = 1'b1;
      end else if (!program_erase_supply_ok_i) begin
        s_nxt.err_supply = 1'b1;
        s_nxt.err_erase = 1'b1;
      end else if (s_r.pend == CI_CHIP) begin
        if (&s_r.blk_lock) begin
          s_nxt.err_protect = 1'b1;
        end else begin
          s_nxt.engine = W_CHIP;
          s_nxt.tgt = '0;
        end
      end else if (s_r.blk_lock[wblk]) begin
        s_nxt.err_protect = 1'b1;
        s_nxt.err_erase = 1'b1;
      end else begin
        s_nxt.engine = W_ERASE;
        s_nxt.tgt = {wblk, {OFS_W{1'b0}}};
      end
    end else if (bus.we && running) begin
      // busy: only suspend and read-status are heard
      if (bus.wdata == CMD_SUSPEND && s_nxt.engine != W_IDLE) begin
        s_nxt.susp_erase = (s_r.engine == W_ERASE);
        s_nxt.susp_write = (s_r.engine == W_WRITE);
        s_nxt.read_status = 1'b1;
      end else if (bus.wdata == CMD_READ_STATUS) begin
        s_nxt.read_status = 1'b1;
      end
    end else if (bus.we) begin
      // single-write commands and setups
      if (bus.wdata == CMD_READ_ARRAY) begin
        s_nxt.read_status = 1'b0;
      end else if (bus.wdata == CMD_READ_STATUS) begin
        s_nxt.read_status = 1'b1;
      end else if (bus.wdata == CMD_CLEAR_STATUS) begin
        s_nxt.err_erase = 1'b0;
        s_nxt.err_write = 1'b0;
        s_nxt.err_supply = 1'b0;
        s_nxt.err_protect = 1'b0;
      end else if (bus.wdata == CMD_CONFIRM) begin
        s_nxt.read_status = 1'b1;
        if (s_r.susp_write || s_r.susp_erase) begin
          s_nxt.susp_write = 1'b0;
          s_nxt.susp_erase = 1'b0;
        end else begin
          s_nxt.err_erase = 1'b1;
          s_nxt.err_write = 1'b1;
        end
      end else if (s_r.engine == W_IDLE) begin
        if (bus.wdata == CMD_BLOCK_ERASE) begin
          s_nxt.pend = CI_ERASE;
        end else if (bus.wdata == CMD_CHIP_ERASE) begin
          s_nxt.pend = CI_CHIP;
        end else if (bus.wdata == CMD_WRITE_A || bus.wdata == CMD_WRITE_B) begin
          s_nxt.pend = CI_WRITE;
        end else if (bus.wdata == CMD_LOCK_SETUP) begin
          s_nxt.pend = CI_LOCK;
        end
      end else if (bus.wdata == CMD_BLOCK_ERASE || bus.wdata == CMD_CHIP_ERASE ||
                   bus.wdata == CMD_WRITE_A || bus.wdata == CMD_WRITE_B ||
                   bus.wdata == CMD_LOCK_SETUP) begin
        s_nxt.err_erase = 1'b1;
        s_nxt.err_write = 1'b1;
      end
    end
    // reset pin: abort, clear flags, keep lock bits
    if (!bus.reset_powerdown_pin_n) begin
      s_nxt = DEV_RST;
      s_nxt.blk_lock = s_r.blk_lock;
      s_nxt.perm_lock = s_r.perm_lock;
      s_nxt.rdata = STATUS_RST & {DATA_W{1'b0}};
      mem_we = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= DEV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array storage, unreset
  always_ff @(posedge ref_clk_i) begin
    if (mem_we) begin
      mem[mem_a] <= mem_d;
    end
  end

  assign bus.rdata = s_r.rdata;

endmodule
`default_nettype wire

// ===== rtl/ffsq_host.sv
// host end: turns user operations into bus command sequences and status polls
`timescale 1ns/1ps
`default_nettype none
module ffsq_host
  import ffsq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // bus to the device
  ffsq_bus_if.host bus,
  // user requests
  input wire logic cmd_valid_i,
  input wire ffsq_op_t cmd_op_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_data_i,
  input wire logic powerdown_i,
  // user answers
  output logic cmd_ready_o,
  output logic done_o,
  output logic [DATA_W-1:0] result_o,
  output logic error_o,
  output logic seq_error_o
);

  typedef struct packed {
    ffsq_hst_t st;
    logic need2;
    logic poll;
    logic mask;
    logic [DATA_W-1:0] code2;
    logic [ADDR_W-1:0] addr;
    logic we;
    logic re;
    logic [ADDR_W-1:0] baddr;
    logic [DATA_W-1:0] wdata;
    logic pd_n;
    logic done;
    logic [DATA_W-1:0] result;
    logic error;
    logic seq_error;
  } ffsq_host_state_t;

  ffsq_host_state_t h_r;
  ffsq_host_state_t h_nxt;
  logic [DATA_W-1:0] code1;
  logic has1;

  ////////////////////////////////////////////////////////////////////////////
  // first code of each operation and the shape of its sequence
  always_comb begin
    code1 = CMD_READ_ARRAY;
    has1 = 1'b1;
    case (cmd_op_i)
      OP_READ: begin
        has1 = 1'b0;
        code1 = 8'h00; // no write goes out; unlike ff, 50 and d0 this code asks for a read
      end
      OP_READ_STATUS: code1 = CMD_READ_STATUS;
      OP_READ_ARRAY_MODE: code1 = CMD_READ_ARRAY;
      OP_CLEAR_STATUS: code1 = CMD_CLEAR_STATUS;
      OP_BLOCK_ERASE: code1 = CMD_BLOCK_ERASE;
      OP_CHIP_ERASE: code1 = CMD_CHIP_ERASE;
      OP_BYTE_WRITE: code1 = CMD_WRITE_A;
      OP_LOCK_BLOCK, OP_LOCK_PERM: code1 = CMD_LOCK_SETUP;
      OP_SUSPEND: code1 = CMD_SUSPEND;
      OP_RESUME: code1 = CMD_CONFIRM;
      default: code1 = CMD_READ_ARRAY;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    h_nxt = h_r;
    h_nxt.we = 1'b0;
    h_nxt.re = 1'b0;
    h_nxt.done = 1'b0;
    h_nxt.pd_n = !powerdown_i;
    case (h_r.st)
      H_IDLE: begin
        if (cmd_valid_i) begin
          h_nxt.addr = cmd_addr_i;
          h_nxt.need2 = (cmd_op_i == OP_BLOCK_ERASE) || (cmd_op_i == OP_CHIP_ERASE) ||
                        (cmd_op_i == OP_BYTE_WRITE) || (cmd_op_i == OP_LOCK_BLOCK) ||
                        (cmd_op_i == OP_LOCK_PERM);
          h_nxt.poll = h_nxt.need2 || (cmd_op_i == OP_SUSPEND);
          h_nxt.mask = h_nxt.poll || (cmd_op_i == OP_READ_STATUS);
          h_nxt.code2 = (cmd_op_i == OP_BYTE_WRITE) ? cmd_data_i :
                        (cmd_op_i == OP_LOCK_BLOCK) ? CMD_LOCK_BLOCK :
                        (cmd_op_i == OP_LOCK_PERM) ? CMD_LOCK_PERM : CMD_CONFIRM;
          h_nxt.baddr = cmd_addr_i;
          h_nxt.wdata = code1;
          h_nxt.we = has1;
          h_nxt.st = has1 ? H_WR1 : H_AFTER;
        end
      end
      H_WR1: begin
        if (h_r.need2) begin
          h_nxt.we = 1'b1;
          h_nxt.wdata = h_r.code2;
          h_nxt.st = H_WR2;
        end else begin
          h_nxt.st = H_AFTER;
        end
      end
      H_WR2: h_nxt.st = H_AFTER;
      H_AFTER: begin
        if (h_r.poll || !h_r.mask && h_r.wdata != CMD_READ_ARRAY && h_r.wdata != CMD_CLEAR_STATUS &&
            h_r.wdata != CMD_CONFIRM || h_r.mask) begin
          h_nxt.re = 1'b1;
          h_nxt.st = H_RD1;
        end else begin
          h_nxt.done = 1'b1;
          h_nxt.st = H_IDLE;
        end
      end
      H_RD1: h_nxt.st = H_RD2;
      H_RD2: begin
        if (h_r.poll && !bus.rdata[SB_READY]) begin
          h_nxt.re = 1'b1;
          h_nxt.st = H_RD1;
        end else begin
          h_nxt.result = h_r.mask ? (bus.rdata & STATUS_MASK) : bus.rdata;
          h_nxt.error = h_r.mask && (bus.rdata[SB_ERASE_ERR] || bus.rdata[SB_WRITE_ERR] ||
                        bus.rdata[SB_SUPPLY_ERR] || bus.rdata[SB_PROTECT]);
          h_nxt.seq_error = h_r.mask && bus.rdata[SB_ERASE_ERR] && bus.rdata[SB_WRITE_ERR];
          h_nxt.done = 1'b1;
          h_nxt.st = H_IDLE;
        end
      end
      default: h_nxt.st = H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      h_r <= '{st: H_IDLE, need2: 1'b0, poll: 1'b0, mask: 1'b0, code2: '0, addr: '0, we: 1'b0,
               re: 1'b0, baddr: '0, wdata: '0, pd_n: 1'b0, done: 1'b0, result: '0,
               error: 1'b0, seq_error: 1'b0};
    end else begin
      h_r <= h_nxt;
    end
  end

  // bus and user outputs straight from the state register
  assign bus.we = h_r.we;
  assign bus.re = h_r.re;
  assign bus.addr = h_r.baddr;
  assign bus.wdata = h_r.wdata;
  assign bus.reset_powerdown_pin_n = h_r.pd_n;
  assign cmd_ready_o = (h_r.st == H_IDLE);
  assign done_o = h_r.done;
  assign result_o = h_r.result;
  assign error_o = h_r.error;
  assign seq_error_o = h_r.seq_error;

endmodule
`default_nettype wire

// ===== rtl/ffsq_pkg.sv
// shared constants and types for the flash command sequencer ends
package ffsq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry of the byte-wide array
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int BLK_W = 4;
  localparam int NUM_BLK = 16;
  localparam int OFS_W = 16;
  localparam int CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // command codes written on the data bus
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_WRITE_A = 8'h40;
  localparam logic [7:0] CMD_WRITE_B = 8'h10;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_PERM = 8'hf1;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;

  ////////////////////////////////////////////////////////////////////////////
  // status_byte bit positions and reset value
  localparam int SB_READY = 7;
  localparam int SB_ERASE_SUSP = 6;
  localparam int SB_ERASE_ERR = 5;
  localparam int SB_WRITE_ERR = 4;
  localparam int SB_SUPPLY_ERR = 3;
  localparam int SB_WRITE_SUSP = 2;
  localparam int SB_PROTECT = 1;
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam logic [7:0] STATUS_MASK = 8'hfe;
  localparam logic [7:0] SUSP_TARGET_DATA = 8'hff;
  localparam logic [7:0] ERASED = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // internal operation times
  localparam int CLK_PERIOD_NS = 10;
  localparam int BYTE_WRITE_NS = 200;
  localparam int LOCK_SET_NS = 500;
  localparam logic [CNT_W-1:0] WRITE_CYC = CNT_W'((BYTE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] LOCK_CYC = CNT_W'((LOCK_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // state enumerations
  typedef enum logic [2:0] {CI_NONE, CI_ERASE, CI_CHIP, CI_WRITE, CI_LOCK} ffsq_pend_t;
  typedef enum logic [2:0] {W_IDLE, W_ERASE, W_CHIP, W_WRITE, W_LOCK} ffsq_engine_t;
  typedef enum logic [2:0] {H_IDLE, H_WR1, H_WR2, H_AFTER, H_RD1, H_RD2} ffsq_hst_t;
  typedef enum logic [3:0] {
    OP_READ, OP_READ_STATUS, OP_READ_ARRAY_MODE, OP_CLEAR_STATUS, OP_BLOCK_ERASE,
    OP_CHIP_ERASE, OP_BYTE_WRITE, OP_LOCK_BLOCK, OP_LOCK_PERM, OP_SUSPEND, OP_RESUME
  } ffsq_op_t;

endpackage
